/* File: design/adc_conversion_sequencer.v */
/*
 * Holds the digital sequencer of a 12-bit converter: clock divider, sampling and
 * conversion phases, input and range selection, single, continuous and accumulation
 * modes, completion flag and interrupt, all behind an AXI4-Lite register slave.
 * Assumes the analogue core samples on sample_hold, presents result_code (saturated)
 * by the end of the conversion phase, and reports regulator readiness.
 * Assumes the register bus master keeps at most one write and one read under way.
 * Assumes software holds the divider and the sampling interval steady while a
 * conversion runs, and waits for regulator readiness before it starts one; the
 * sequencer itself does not hold a start back on regulator readiness.
 */
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
//
// Contract
// R1: Converter clock is the system clock divided by a software-set divider.
// R2: Sampling interval selectable as 2, 4, 6 or 8 converter clock periods.
// R3: Sampling phase lasts three sampling intervals before conversion starts.
// R4: Conversion phase lasts exactly 14 converter clock periods.
// R5: Software should normally pick the 2-period sampling interval.
// R6: A setting picks internal or external reference voltage.
// R7: Range is 0..Vref or 0..2Vref; out-of-range inputs give saturated code.
// R8: Regulator enabled by setting, readiness visible; software waits for it.
// R9: With enable set, interrupt on each completed conversion; else none. In accumulation the code raises it once only, when the run ends.
// R10: Input multiplexer selects one of six sources.
// R11: Enabling never starts conversion; only a start command does.
// R12: Single-shot start makes exactly one conversion, then idle.
// R13: Continuous and accumulation start next conversion immediately.
// R14: Accumulation performs a fixed count and presents the sum, then stops.
// R15: Accumulation count 2, 4, 8 or 16; accumulation overrides mode setting.
// R16: Each conversion samples once and holds for the conversion, 12 bits.
// R17: Only the converter raises the analogue peripheral interrupt.
// R18: Continuous result stays unchanged until the next conversion completes.
// R19: A pollable flag shows the conversion or whole run has finished.
// R20: Stop or disable ends any sequence at once, no interrupt.
// R21: Completion flag clears on accepted start, sets when the run ends.
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module adc_conversion_sequencer #(
    parameter DATA_W = 12,
    parameter DIV_W = `CFG_DIV_W
) (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // AXI4-Lite write address.
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address.
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data.
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analogue core.
    output reg conv_clk,
    output reg sample_hold,
    output reg convert_active,
    output reg [2:0] input_select,
    output reg range_double,
    output reg ref_external,
    output reg regulator_enable,
    input wire regulator_ready,
    input wire [DATA_W-1:0] result_code,
    // Interrupt.
    output reg analogue_peripheral_interrupt
);

    // ------------------------------------------------------------------------
    // Local definitions
    // ------------------------------------------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_SAMPLE = 2'd1;
    localparam ST_CONVERT = 2'd2;
    localparam SUM_W = DATA_W + 4;
    localparam [31:0] CONV_LAST_FULL = `CONV_PERIODS - 1;
    localparam [4:0] CONV_LAST = CONV_LAST_FULL[4:0];

    // Sampling-phase length in converter periods: three intervals of 2, 4, 6 or 8.
    function [4:0] sample_len;
        input [1:0] sel;
        reg [31:0] len_full;
        begin
            len_full = `SAMPLE_MULT * ({3'd0, sel} + 5'd1) * 2;
            sample_len = len_full[4:0];
        end
    endfunction

    // Accumulation count 2, 4, 8 or 16 from a two-bit selector.
    function [4:0] acc_len;
        input [1:0] sel;
        begin
            acc_len = 5'd2 << sel;
        end
    endfunction

    reg [31:0] cfg_q;
    reg [31:0] en_q;
    reg [1:0] state_q;
    reg [DIV_W-1:0] div_cnt_q;
    reg [4:0] phase_cnt_q;
    reg [4:0] acc_left_q;
    reg acc_mode_q;
    reg [SUM_W-1:0] sum_q;
    reg [SUM_W-1:0] result_q;
    reg done_q;
    reg rdy_q;
    reg [7:0] aw_q;
    reg aw_have_q;
    reg [31:0] w_q;
    reg w_have_q;
    reg [3:0] wstrb_q;

    wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    wire [7:0] wr_addr = aw_q;
    wire start_wr = wr_fire && wr_addr == `OFS_START && wstrb_q[0];
    wire go_cmd = start_wr && w_q[`ST_GO_BIT] && en_q[`EN_ON_BIT] && !w_q[`ST_STOP_BIT];
    wire stop_cmd = (start_wr && w_q[`ST_STOP_BIT]) || !en_q[`EN_ON_BIT];
    wire tick = div_cnt_q == cfg_q[`CFG_DIV_LSB +: DIV_W];
    wire conv_end = state_q == ST_CONVERT && tick && conv_clk && phase_cnt_q == CONV_LAST;
    wire [4:0] sample_last = sample_len(cfg_q[`CFG_SINT_LSB +: 2]) - 5'd1;
    wire [SUM_W-1:0] sum_next = sum_q + {{(SUM_W-DATA_W){1'b0}}, result_code};

    // ------------------------------------------------------------------------
    // Register write slave
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            cfg_q <= `CFG_RESET;
            en_q <= `EN_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                case (wr_addr)
                    `OFS_CONFIG: begin
                        if (wstrb_q[0]) cfg_q[7:0] <= w_q[7:0]; // see R1
                        if (wstrb_q[1]) cfg_q[12:8] <= w_q[12:8]; // see R2
                    end
                    `OFS_ENABLE: begin
                        if (wstrb_q[0]) en_q[6:0] <= w_q[6:0]; // see R11
                    end
                    `OFS_START, `OFS_STATUS, `OFS_RESULT: begin
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register read slave
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
                `OFS_CONFIG: s_axi_rdata <= {19'h0, cfg_q[12:0]};
                `OFS_ENABLE: s_axi_rdata <= {25'h0, en_q[6:0]};
                `OFS_START: s_axi_rdata <= 32'h0000_0000;
                `OFS_STATUS: s_axi_rdata <= {29'h0, rdy_q, state_q != ST_IDLE, done_q}; // see R19
                `OFS_RESULT: s_axi_rdata <= {{(32-SUM_W){1'b0}}, result_q}; // see R18
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_q <= {DIV_W{1'b0}};
            conv_clk <= 1'b0;
        end else if (tick || state_q == ST_IDLE) begin
            div_cnt_q <= {DIV_W{1'b0}};
            conv_clk <= (state_q == ST_IDLE) ? 1'b0 : ~conv_clk; // see R1
        end else begin
            div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            phase_cnt_q <= 5'd0;
            acc_left_q <= 5'd0;
            acc_mode_q <= 1'b0;
            sum_q <= {SUM_W{1'b0}};
            result_q <= {SUM_W{1'b0}};
            done_q <= 1'b0;
            analogue_peripheral_interrupt <= 1'b0;
            sample_hold <= 1'b0;
            convert_active <= 1'b0;
        end else begin
            analogue_peripheral_interrupt <= 1'b0;
            if (stop_cmd && state_q != ST_IDLE) begin
                state_q <= ST_IDLE; // see R20
                sample_hold <= 1'b0;
                convert_active <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (go_cmd) begin
                            state_q <= ST_SAMPLE; // see R11
                            phase_cnt_q <= 5'd0;
                            done_q <= 1'b0; // see R21
                            acc_mode_q <= w_q[`ST_ACC_BIT]; // see R15
                            acc_left_q <= acc_len(w_q[`ST_ACCN_LSB +: 2]);
                            sum_q <= {SUM_W{1'b0}};
                            sample_hold <= 1'b1;
                        end
                    end
                    ST_SAMPLE: begin
                        if (tick && conv_clk) begin
                            if (phase_cnt_q == sample_last) begin // see R2
                                state_q <= ST_CONVERT; // see R3
                                phase_cnt_q <= 5'd0;
                                sample_hold <= 1'b0; // see R16
                                convert_active <= 1'b1;
                            end else begin
                                phase_cnt_q <= phase_cnt_q + 5'd1;
                            end
                        end
                    end
                    ST_CONVERT: begin
                        if (conv_end) begin // see R4
                            convert_active <= 1'b0;
                            // see R9 see R17
                            analogue_peripheral_interrupt <= cfg_q[`CFG_IRQ_EN_BIT] &&
                                (!acc_mode_q || acc_left_q == 5'd1);
                            if (acc_mode_q) begin
                                sum_q <= sum_next; // see R14
                                acc_left_q <= acc_left_q - 5'd1;
                                if (acc_left_q == 5'd1) begin
                                    result_q <= sum_next;
                                    done_q <= 1'b1;
                                    state_q <= ST_IDLE;
                                end else begin
                                    state_q <= ST_SAMPLE; // see R13
                                    sample_hold <= 1'b1;
                                end
                            end else begin
                                result_q <= {{(SUM_W-DATA_W){1'b0}}, result_code}; // see R18
                                done_q <= 1'b1; // see R19
                                if (en_q[`EN_CONT_BIT]) begin
                                    state_q <= ST_SAMPLE; // see R13
                                    sample_hold <= 1'b1;
                                end else begin
                                    state_q <= ST_IDLE; // see R12
                                end
                            end
                            phase_cnt_q <= 5'd0;
                        end else if (tick && conv_clk) begin
                            phase_cnt_q <= phase_cnt_q + 5'd1;
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Analogue controls
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_select <= 3'd0;
            range_double <= 1'b0;
            ref_external <= 1'b0;
            regulator_enable <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            input_select <= (en_q[`EN_SRC_LSB +: 3] > 3'd5) ? 3'd5 : en_q[`EN_SRC_LSB +: 3]; // see R10
            range_double <= en_q[`EN_RANGE2_BIT]; // see R7
            ref_external <= cfg_q[`CFG_REFEXT_BIT]; // see R6
            regulator_enable <= cfg_q[`CFG_REG_EN_BIT]; // see R8
            rdy_q <= regulator_ready && cfg_q[`CFG_REG_EN_BIT]; // see R8
        end
    end

endmodule // adc_conversion_sequencer

/* File: dv/adc_core_model.sv */
/* Stand-in for the analogue sample-and-hold and converter core.
   Assumes the sequencer's core-side ports and one system clock. */
`timescale 1ns/1ps
module adc_core_model (
    // Sequencer side.
    input wire clk,
    input wire sample_hold,
    input wire [2:0] input_select,
    input wire range_double,
    input wire ref_external,
    input wire regulator_enable,
    output logic regulator_ready,
    output logic [11:0] result_code
);
    logic [4:0] settle_q = 5'h00;
    logic [11:0] held_q = 12'h000;
    logic track_q = 1'b0;
    // The regulator settles some cycles after it is switched on.
    always @(posedge clk) begin
        settle_q <= !regulator_enable ? 5'h00 : settle_q + {4'h0, settle_q != 5'h1f};
        track_q <= sample_hold;
        if (track_q && !sample_hold)
            held_q <= {1'b0, input_select, range_double, ref_external, 6'h2b};
    end
    assign regulator_ready = settle_q == 5'h1f;
    // While tracking the code is not valid, so the inverse is shown.
    assign result_code = sample_hold ? ~held_q : held_q;
endmodule // adc_core_model

/* File: dv/adc_seq_props.sv */
/* Port checker for the conversion sequencer.
   Assumes it is bound to every sequencer instance. */
`timescale 1ns/1ps
module adc_seq_props (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Register bus.
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Core and interrupt.
    input wire sample_hold,
    input wire convert_active,
    input wire [2:0] input_select,
    input wire analogue_peripheral_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_phase_apart: assert property (!(sample_hold && convert_active))
        else $error("sampling and conversion overlap");
    a_convert_follows: assert property ($rose(convert_active) |-> $past(sample_hold))
        else $error("conversion began without sampling");
    a_irq_pulse: assert property (analogue_peripheral_interrupt |=> !analogue_peripheral_interrupt)
        else $error("interrupt longer than one cycle");
    a_irq_at_end: assert property (analogue_peripheral_interrupt |->
        $past(convert_active) || $past(convert_active, 2))
        else $error("interrupt not at end of conversion");
    a_source_legal: assert property (input_select <= 3'h5)
        else $error("source select beyond six sources");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    cover property (analogue_peripheral_interrupt);
    cover property ($rose(convert_active));
    cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // adc_seq_props
bind adc_conversion_sequencer adc_seq_props adc_seq_props_inst (.*);

/* File: dv/tb_adc_conversion_sequencer.sv */
/* Self-checking bench for the conversion sequencer.
   Assumes the sequencer, its map header, the core model and the checker. */
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module tb_adc_conversion_sequencer;
    logic clk, resetn, sh_q, cc_q;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic conv_clk, sample_hold, convert_active, range_double, ref_external;
    logic regulator_enable, regulator_ready, analogue_peripheral_interrupt;
    logic [2:0] input_select;
    logic [11:0] result_code;
    int miscompares, n_compared, irqs, starts, n, m, k, s, b, sh_n, ca_n, cc_n;
    adc_conversion_sequencer adc_conversion_sequencer_inst (.*);
    adc_core_model adc_core_model_inst (.*);
    // ------------------------------------------------------------------
    // Bus tasks and comparison.
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, r);
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check(s_axi_rresp, r);
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
        rd(a, 2'b00);
        check(rv & mk, e);
    endtask
    task automatic wait_done();
        rv = 32'h0;
        for (k = 0; k < 300 && rv[0] !== 1'b1; k++) rd(`OFS_STATUS, 2'b00);
        check(rv[1:0], 32'h1);
    endtask
    function automatic logic [31:0] code(input int src, input logic rg, input logic ex);
        return {20'h0, 1'b0, src[2:0], rg, ex, 6'h2b};
    endfunction
    task automatic go_single();
        wr(`OFS_START, 32'h1, 2'b00);
        wait_done();
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset_map();
        rchk(`OFS_CONFIG, 32'hffffffff, `CFG_RESET);
        rchk(`OFS_ENABLE, 32'hffffffff, `EN_RESET);
        rchk(`OFS_START, 32'hffffffff, 32'h0);
        rd(8'h20, `RESP_SLVERR);
        wr(8'h20, 32'h1, `RESP_SLVERR);
        wr(`OFS_CONFIG, 32'h1800, 2'b00);
        check(regulator_enable, 1'b1);
        for (k = 0; k < 100 && rv[2] !== 1'b1; k++) rd(`OFS_STATUS, 2'b00);
        check(rv[2], 1'b1);
    endtask
    task automatic t_single();
        wr(`OFS_ENABLE, 32'h21, 2'b00);
        repeat (40) @(posedge clk);
        check(starts, 0);
        wr(`OFS_START, 32'h1, 2'b00);
        rchk(`OFS_STATUS, 32'h3, 32'h2);
        wait_done();
        repeat (60) @(posedge clk);
        check(starts, 1);
        check(irqs, 1);
        rchk(`OFS_RESULT, 32'hffff, code(2, 0, 0));
    endtask
    task automatic t_timing();
        for (s = 0; s < 4; s++) begin
            wr(`OFS_CONFIG, 32'h1801 | (s << 8), 2'b00);
            n = sh_n;
            m = ca_n;
            b = cc_n;
            wr(`OFS_START, 32'h1, 2'b00);
            wait_done();
            check(sh_n - n, 24 * (s + 1));
            check(ca_n - m, 56);
            check(cc_n - b, 6 * (s + 1) + 14);
        end
    endtask
    task automatic t_sources();
        wr(`OFS_CONFIG, 32'h1c00, 2'b00);
        check(ref_external, 1'b1);
        for (s = 0; s < 8; s++) begin
            wr(`OFS_ENABLE, (s << 4) | ((s & 1) << 2) | 1, 2'b00);
            check(input_select, (s > 5) ? 5 : s);
            check(range_double, s & 1);
            go_single();
            rchk(`OFS_RESULT, 32'hffff, code((s > 5) ? 5 : s, s & 1, 1));
        end
    endtask
    task automatic t_accum();
        wr(`OFS_ENABLE, 32'h23, 2'b00);
        for (s = 0; s < 4; s++) begin
            n = irqs;
            m = starts;
            wr(`OFS_START, 32'h3 | (s << 2), 2'b00);
            wait_done();
            repeat (60) @(posedge clk);
            check(starts - m, 2 << s);
            check(irqs - n, 1);
            rchk(`OFS_RESULT, 32'hffff, (2 << s) * code(2, 0, 1));
        end
    endtask
    task automatic t_cont();
        wr(`OFS_START, 32'h1, 2'b00);
        k = 0;
        n = 0;
        while (k < 3) begin
            @(posedge clk);
            if (k > 0) n++;
            if (analogue_peripheral_interrupt === 1'b1) k++;
        end
        check(n, 80);
        rchk(`OFS_RESULT, 32'hffff, code(2, 0, 1));
        wr(`OFS_START, 32'h10, 2'b00);
        check({sample_hold, convert_active}, 2'b00);
        m = irqs;
        wr(`OFS_START, 32'h1, 2'b00);
        repeat (10) @(posedge clk);
        wr(`OFS_ENABLE, 32'h0, 2'b00);
        repeat (100) @(posedge clk);
        check(irqs - m, 0);
        check({sample_hold, convert_active}, 2'b00);
        wr(`OFS_CONFIG, 32'h0c00, 2'b00);
        wr(`OFS_ENABLE, 32'h21, 2'b00);
        go_single();
        check(irqs - m, 0);
    endtask
    // ------------------------------------------------------------------
    // Clock, monitor, watchdog and main sequence.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (analogue_peripheral_interrupt === 1'b1)
            irqs++;
        if (sample_hold === 1'b1 && sh_q !== 1'b1)
            starts++;
        if (sample_hold === 1'b1)
            sh_n++;
        if (convert_active === 1'b1)
            ca_n++;
        if (conv_clk === 1'b1 && cc_q !== 1'b1)
            cc_n++;
        sh_q <= sample_hold;
        cc_q <= conv_clk;
    end
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        close_out();
    end
    initial begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset_map();
        t_single();
        t_timing();
        t_sources();
        t_accum();
        t_cont();
        close_out();
    end
endmodule // tb_adc_conversion_sequencer

/* File: shared/adc_seq_map.vh */
/*
 * Holds the register offsets, field positions, reset values and timing figures of the
 * conversion sequencer.
 * Assumes it is included by its bare name from the sequencer design file.
 */
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_ENABLE 8'h04
`define OFS_START 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RESULT 8'h10

// ----------------------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------------------
`define CFG_DIV_LSB 0
`define CFG_DIV_W 8
`define CFG_SINT_LSB 8
`define CFG_REFEXT_BIT 10
`define CFG_REG_EN_BIT 11
`define CFG_IRQ_EN_BIT 12
`define CFG_RESET 32'h0000_0f0f

// ----------------------------------------------------------------------------
// Enable register fields
// ----------------------------------------------------------------------------
`define EN_ON_BIT 0
`define EN_CONT_BIT 1
`define EN_RANGE2_BIT 2
`define EN_SRC_LSB 4
`define EN_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// Start register fields
// ----------------------------------------------------------------------------
`define ST_GO_BIT 0
`define ST_ACC_BIT 1
`define ST_ACCN_LSB 2
`define ST_STOP_BIT 4

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define SR_DONE_BIT 0
`define SR_BUSY_BIT 1
`define SR_REG_RDY_BIT 2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SYS_CLK_KHZ 16000
`define TARGET_KHZ 500
`define CONV_PERIODS 14
`define SAMPLE_MULT 3

// AXI responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif
